/* File: verilog/cmc_pkg.sv */
// constants, types and field layout of the comparator one control register
// Function
// - the result bit reads high when the positive input is above the negative input, low otherwise, and ignores writes.
// - with the pin-drive bit 6 clear the result is driven on the output pin, with it set the pin is not driven.
// - polarity bit 5 set passes the result unchanged, clear inverts it.
// - with timer source bit 4 set, the timer clock follows the timer's own clock select.
// - with timer source bit 4 clear, the comparator output becomes the timer clock source.
// - enable bit 3 switches the comparator on when set and off when clear.
// - negative select bit 2 picks the external negative pin when set, the internal reference when clear.
// - positive select bit 1 picks which external pin feeds the positive input.
// - wake bit 0 set disables wake on comparator change, clear enables it.
// - pin drive, timer source, wake, both input selects and the result bit act only while the comparator enable is set.
package cmc_pkg;
    localparam logic [7:0] CMC_CTRL_OFFSET = 8'h08;
    localparam logic [7:0] CMC_CTRL_RESET = 8'hff;
    localparam int CMC_RESULT_BIT = 7;
    localparam int CMC_PIN_DRIVE_N_BIT = 6;
    localparam int CMC_POLARITY_BIT = 5;
    localparam int CMC_TIMER_SRC_N_BIT = 4;
    localparam int CMC_ENABLE_BIT = 3;
    localparam int CMC_NEG_SEL_BIT = 2;
    localparam int CMC_POS_SEL_BIT = 1;
    localparam int CMC_WAKE_N_BIT = 0;
    localparam logic [1:0] CMC_RESP_OKAY = 2'b00;
    localparam logic [1:0] CMC_RESP_SLVERR = 2'b10;

    // analog control outputs toward the comparator macro
    typedef struct packed {
        logic enable;
        logic neg_input_select;
        logic pos_input_select;
    } cmc_analog_ctrl_t;

    // digital routes of the comparator output
    typedef struct packed {
        logic pin_out;
        logic pin_oe_n;
        logic timer_clk;
        logic wake_enable;
    } cmc_route_t;
endpackage : cmc_pkg

/* File: verilog/cmc_ctrl_store.sv */
// storage of the seven writable control bits
`timescale 1ns/1ps
module cmc_ctrl_store #(
    parameter int WIDTH = 7
) (
    input wire logic sys_clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic wr_en, // write strobe
    input wire logic [WIDTH-1:0] wr_data, // new control bits
    input wire logic [WIDTH-1:0] wr_mask, // byte lane mask
    output logic [WIDTH-1:0] ctrl_q // stored control bits
);
    // elaboration check: the layout serves exactly seven writable bits
    if (WIDTH != 7) begin : g_bad_width
        $error("cmc_ctrl_store width must be 7");
    end

    logic [WIDTH-1:0] ctrl_reg;
    logic [WIDTH-1:0] ctrl_next;

    // merge masked write
    always_comb begin
        ctrl_next = ctrl_reg;
        if (wr_en) begin
            ctrl_next = (ctrl_reg & ~wr_mask) | (wr_data & wr_mask);
        end
    end

    // register, all ones after reset
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ctrl_reg <= cmc_pkg::CMC_CTRL_RESET[WIDTH-1:0];
        end else begin
            ctrl_reg <= ctrl_next;
        end
    end

    assign ctrl_q = ctrl_reg;
endmodule : cmc_ctrl_store

/* File: verilog/cmc_top.sv */
// axi4-lite control register of comparator one with output routing
`timescale 1ns/1ps
module cmc_top (
    input wire logic sys_clk, // system clock
    input wire logic reset, // async reset, active high
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic cmp_raw, // analog comparator, high when pos above neg
    input wire logic timer_clock_select, // timer's own clock select result
    output cmc_pkg::cmc_analog_ctrl_t analog_ctrl, // controls to analog macro
    output cmc_pkg::cmc_route_t route // digital routes of result
);
    ////////////////////////////////////////////////////////////////////////
    // write channel
    logic aw_held_reg, aw_held_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic w_held_reg, w_held_next;
    logic [31:0] w_data_reg, w_data_next;
    logic [3:0] w_strb_reg, w_strb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic wr_en;
    logic [6:0] ctrl_q;
    logic [6:0] wr_mask;

    // word decode used by both channels
    function automatic logic hits_ctrl(input logic [7:0] addr);
        return addr[7:2] == cmc_pkg::CMC_CTRL_OFFSET[7:2];
    endfunction : hits_ctrl

    assign s_axi_awready = !aw_held_reg && !bvalid_reg;
    assign s_axi_wready = !w_held_reg && !bvalid_reg;
    assign wr_en = aw_held_reg && w_held_reg && !bvalid_reg && hits_ctrl(aw_addr_reg);
    assign wr_mask = w_strb_reg[0] ? 7'h7f : 7'h00;

    // capture address and data in any order, then respond
    always_comb begin
        aw_held_next = aw_held_reg;
        aw_addr_next = aw_addr_reg;
        w_held_next = w_held_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held_next = 1'b1;
            w_data_next = s_axi_wdata;
            w_strb_next = s_axi_wstrb;
        end
        if (aw_held_reg && w_held_reg && !bvalid_reg) begin
            bvalid_next = 1'b1;
            bresp_next = hits_ctrl(aw_addr_reg) ? cmc_pkg::CMC_RESP_OKAY
                                                : cmc_pkg::CMC_RESP_SLVERR;
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
    end

    // write channel registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= cmc_pkg::CMC_RESP_OKAY;
        end else begin
            aw_held_reg <= aw_held_next;
            aw_addr_reg <= aw_addr_next;
            w_held_reg <= w_held_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;

    // writable bits 6..0; result bit 7 has no storage, writes ignored
    cmc_ctrl_store #(.WIDTH(7)) u_store (
        .sys_clk(sys_clk),
        .reset(reset),
        .wr_en(wr_en),
        .wr_data(w_data_reg[6:0]),
        .wr_mask(wr_mask),
        .ctrl_q(ctrl_q)
    );

    ////////////////////////////////////////////////////////////////////////
    // comparator output and routing
    logic enable;
    logic result;
    assign enable = ctrl_q[cmc_pkg::CMC_ENABLE_BIT];
    // gated by enable, polarity applied
    assign result = enable && (ctrl_q[cmc_pkg::CMC_POLARITY_BIT] ? cmp_raw : !cmp_raw);

    logic [3:0] route_reg, route_next;
    // route next: pin, pin enable low, timer clock, wake enable
    always_comb begin
        route_next[3] = result;
        route_next[2] = !(enable && !ctrl_q[cmc_pkg::CMC_PIN_DRIVE_N_BIT]);
        route_next[1] = (enable && !ctrl_q[cmc_pkg::CMC_TIMER_SRC_N_BIT]) ? result
                                                                       : timer_clock_select;
        route_next[0] = enable && !ctrl_q[cmc_pkg::CMC_WAKE_N_BIT];
    end

    // route flip-flops
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            route_reg <= 4'h4;
        end else begin
            route_reg <= route_next;
        end
    end

    assign route = cmc_pkg::cmc_route_t'(route_reg);
    assign analog_ctrl.enable = enable;
    // selects only meaningful while on
    assign analog_ctrl.neg_input_select = enable && ctrl_q[cmc_pkg::CMC_NEG_SEL_BIT];
    assign analog_ctrl.pos_input_select = enable && ctrl_q[cmc_pkg::CMC_POS_SEL_BIT];

    ////////////////////////////////////////////////////////////////////////
    // read channel
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    assign s_axi_arready = !rvalid_reg;

    // single-cycle read answer
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            if (hits_ctrl(s_axi_araddr)) begin
                rdata_next = {24'h00_0000, result, ctrl_q};
                rresp_next = cmc_pkg::CMC_RESP_OKAY;
            end else begin
                rdata_next = 32'h0000_0000;
                rresp_next = cmc_pkg::CMC_RESP_SLVERR;
            end
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
    end

    // read registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= cmc_pkg::CMC_RESP_OKAY;
        end else begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_pin_drive;
        @(posedge sys_clk) disable iff (reset)
        (enable && !ctrl_q[cmc_pkg::CMC_PIN_DRIVE_N_BIT]) |=> !route.pin_oe_n;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin not driven");
    property p_polarity;
        @(posedge sys_clk) disable iff (reset)
        (enable && ctrl_q[cmc_pkg::CMC_POLARITY_BIT]) |-> result == cmp_raw;
    endproperty
    a_polarity: assert property (p_polarity) else $error("polarity wrong");
    property p_timer_own;
        @(posedge sys_clk) disable iff (reset)
        ctrl_q[cmc_pkg::CMC_TIMER_SRC_N_BIT] |=> route.timer_clk == $past(timer_clock_select);
    endproperty
    a_timer_own: assert property (p_timer_own) else $error("timer source wrong");
    property p_timer_cmp;
        @(posedge sys_clk) disable iff (reset)
        (enable && !ctrl_q[cmc_pkg::CMC_TIMER_SRC_N_BIT]) |=> route.timer_clk == $past(result);
    endproperty
    a_timer_cmp: assert property (p_timer_cmp) else $error("timer not from cmp");
    property p_off;
        @(posedge sys_clk) disable iff (reset)
        !enable |=> !route.wake_enable && route.pin_oe_n && !route.pin_out;
    endproperty
    a_off: assert property (p_off) else $error("active while off");
    property p_wake;
        @(posedge sys_clk) disable iff (reset)
        ctrl_q[cmc_pkg::CMC_WAKE_N_BIT] |=> !route.wake_enable;
    endproperty
    a_wake: assert property (p_wake) else $error("wake not disabled");
    property p_read_result;
        @(posedge sys_clk) disable iff (reset)
        (s_axi_arvalid && !rvalid_reg && hits_ctrl(s_axi_araddr))
            |=> s_axi_rdata[cmc_pkg::CMC_RESULT_BIT] == $past(result);
    endproperty
    a_read_result: assert property (p_read_result) else $error("result misread");
    property p_neg_sel;
        @(posedge sys_clk) disable iff (reset)
        enable |-> analog_ctrl.neg_input_select == ctrl_q[cmc_pkg::CMC_NEG_SEL_BIT];
    endproperty
    a_neg_sel: assert property (p_neg_sel) else $error("neg select wrong");
endmodule : cmc_top

/* File: sim/tb_cmc_top.sv */
// self-checking bench for the comparator one control register
`timescale 1ns/1ps
module tb_cmc_top;
    logic sys_clk = 0;
    logic reset = 1;
    logic [7:0] awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic cmp_raw = 0, tcs = 0;
    cmc_pkg::cmc_analog_ctrl_t analog_ctrl;
    cmc_pkg::cmc_route_t route;
    int fail_count = 0, checks_done = 0;

    always #5 sys_clk = ~sys_clk;

    cmc_top u_cmc_top (.sys_clk(sys_clk), .reset(reset), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .cmp_raw(cmp_raw), .timer_clock_select(tcs),
        .analog_ctrl(analog_ctrl), .route(route));

    ////////////////////////////////////////////////////////////////////////
    // verdict and comparison helpers
    task automatic conclude();
        if (fail_count == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            fail_count++;
        end
    endtask : chk

    task automatic timeout(input string nm);
        $display("[ERR] %s expected handshake seen none", nm);
        fail_count++;
        conclude();
    endtask : timeout

    ////////////////////////////////////////////////////////////////////////
    // axi4-lite master cycles
    // ready and answers are sampled at the falling edge, settled for the next rise
    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                          input logic [1:0] er);
        int n;
        logic ad, wd, aw_rdy, w_rdy, b_seen;
        logic [1:0] resp;
        ad = 0;
        wd = 0;
        aw_rdy = 0;
        w_rdy = 0;
        b_seen = 0;
        resp = 2'b00;
        n = 0;
        awaddr <= a;
        awvalid <= 1;
        wdata <= {24'h00_0000, d};
        wstrb <= s;
        wvalid <= 1;
        bready <= 1;
        while (!(ad && wd)) begin
            @(negedge sys_clk);
            aw_rdy = awready;
            w_rdy = wready;
            @(posedge sys_clk);
            if (!ad && aw_rdy) begin
                ad = 1;
                awvalid <= 0;
            end
            if (!wd && w_rdy) begin
                wd = 1;
                wvalid <= 0;
            end
            n++;
            if (n > 20) timeout("awready wready");
        end
        while (!b_seen) begin
            @(negedge sys_clk);
            b_seen = bvalid;
            resp = bresp;
            @(posedge sys_clk);
            n++;
            if (n > 40) timeout("bvalid");
        end
        bready <= 0;
        chk("bresp", {30'h0, er}, {30'h0, resp});
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ar_rdy, r_seen;
        logic [31:0] data;
        logic [1:0] resp;
        n = 0;
        ar_rdy = 0;
        r_seen = 0;
        data = 32'h0000_0000;
        resp = 2'b00;
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (!ar_rdy) begin
            @(negedge sys_clk);
            ar_rdy = arready;
            @(posedge sys_clk);
            n++;
            if (n > 20) timeout("arready");
        end
        arvalid <= 0;
        while (!r_seen) begin
            @(negedge sys_clk);
            r_seen = rvalid;
            data = rdata;
            resp = rresp;
            @(posedge sys_clk);
            n++;
            if (n > 40) timeout("rvalid");
        end
        rready <= 0;
        chk("rresp", {30'h0, er}, {30'h0, resp});
        chk("rdata", ed, data);
    endtask : axi_rd

    // drive the analog side and let the registered routes follow
    task automatic set_in(input logic c, input logic t);
        cmp_raw <= c;
        tcs <= t;
        repeat (3) @(posedge sys_clk);
    endtask : set_in

    task automatic chk_out(input logic [3:0] r, input logic [2:0] an);
        chk("route", {28'h0, r}, {28'h0, route.pin_out, route.pin_oe_n, route.timer_clk,
            route.wake_enable});
        chk("analog_ctrl", {29'h0, an}, {29'h0, analog_ctrl});
    endtask : chk_out

    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset();
        set_in(1, 0);
        axi_rd(8'h08, 32'h0000_00ff, cmc_pkg::CMC_RESP_OKAY);
        chk_out(4'b1100, 3'b111);
        set_in(1, 1);
        chk_out(4'b1110, 3'b111);
    endtask : t_reset

    task automatic t_routes();
        axi_wr(8'h08, 8'h28, 4'h1, cmc_pkg::CMC_RESP_OKAY);
        set_in(1, 0);
        axi_rd(8'h08, 32'h0000_00a8, cmc_pkg::CMC_RESP_OKAY);
        chk_out(4'b1011, 3'b100);
        set_in(0, 1);
        axi_rd(8'h08, 32'h0000_0028, cmc_pkg::CMC_RESP_OKAY);
        chk_out(4'b0001, 3'b100);
        axi_wr(8'h08, 8'h08, 4'h1, cmc_pkg::CMC_RESP_OKAY);
        set_in(0, 0);
        axi_rd(8'h08, 32'h0000_0088, cmc_pkg::CMC_RESP_OKAY);
        chk("pin", 32'h2, {30'h0, route.pin_out, route.pin_oe_n});
    endtask : t_routes

    task automatic t_disable();
        axi_wr(8'h08, 8'ha0, 4'h1, cmc_pkg::CMC_RESP_OKAY);
        set_in(1, 1);
        axi_rd(8'h08, 32'h0000_0020, cmc_pkg::CMC_RESP_OKAY);
        chk_out(4'b0110, 3'b000);
    endtask : t_disable

    task automatic t_bus();
        axi_wr(8'h08, 8'h0e, 4'h0, cmc_pkg::CMC_RESP_OKAY);
        axi_rd(8'h08, 32'h0000_0020, cmc_pkg::CMC_RESP_OKAY);
        axi_wr(8'h0c, 8'h0e, 4'h1, cmc_pkg::CMC_RESP_SLVERR);
        axi_rd(8'h0c, 32'h0000_0000, cmc_pkg::CMC_RESP_SLVERR);
        axi_wr(8'h08, 8'h0e, 4'h1, cmc_pkg::CMC_RESP_OKAY);
        set_in(1, 0);
        axi_rd(8'h08, 32'h0000_000e, cmc_pkg::CMC_RESP_OKAY);
        chk_out(4'b0001, 3'b111);
    endtask : t_bus

    ////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 0;
        @(posedge sys_clk);
        t_reset();
        t_routes();
        t_disable();
        t_bus();
        conclude();
    end
endmodule : tb_cmc_top
